/* File: include/pcv_pkg.sv */
package pcv_pkg;
    localparam int unsigned CLK_HZ       = 25_000_000;
    localparam int unsigned MAX_EDGE_HZ  = 1_000_000;
    // shortest pin phase at the top rate, in cycles (rounded down)
    localparam int unsigned MIN_PHASE_CYC = CLK_HZ / (2 * MAX_EDGE_HZ);
    localparam int unsigned LAT_CYC_DEF  = 32'd2500;
    localparam int unsigned OFF_CYC_DEF  = 32'd12500;
    localparam int unsigned TMR_W        = 16;
    localparam logic [3:0]  CODE_DEFAULT = 4'h0;
    localparam logic [3:0]  CODE_MAX     = 4'hF;
    // low reference in millivolts: base plus step per code
    localparam logic [10:0] LOW_REF_BASE_MV = 11'd600;
    localparam logic [10:0] LOW_REF_STEP_MV = 11'd40;
    localparam logic [10:0] HIGH_REF_MV     = 11'd1200;

    typedef struct packed {
        logic        pin_q;
        logic        enabled;
        logic        pending;
        logic [4:0]  edges;
        logic [3:0]  code;
        logic [TMR_W-1:0] tmr;
    } pcv_state_t;

    typedef struct packed {
        logic        high_ref_en;
        logic        low_ref_en;
        logic [3:0]  low_ref_code;
        logic [10:0] ref_mv;
    } pcv_ref_t;
endpackage : pcv_pkg

/* File: rtl/pcv_select.sv */
`timescale 1ns/1ps
module pcv_select #(
    parameter logic [pcv_pkg::TMR_W-1:0] LAT_CYC = pcv_pkg::TMR_W'(pcv_pkg::LAT_CYC_DEF),
    parameter logic [pcv_pkg::TMR_W-1:0] OFF_CYC = pcv_pkg::TMR_W'(pcv_pkg::OFF_CYC_DEF)
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic             en_set,
    input  wire logic             ref_sel,
    output logic                  enabled,
    output pcv_pkg::pcv_ref_t     ref_out
);
    pcv_pkg::pcv_state_t st_r;
    pcv_pkg::pcv_state_t st_nxt;
    pcv_pkg::pcv_ref_t   ref_nxt;
    logic                rise;
    logic                latch_now;
    logic                off_now;

    ////////////////////////////////////////////////////////////////////////////
    // edge count, latch and shutdown
    assign rise = en_set & ~st_r.pin_q;
    // latch and shutdown only time the phase the pin is in now
    assign latch_now = en_set & st_r.pin_q & st_r.pending
                       & (st_r.tmr >= LAT_CYC);
    assign off_now   = ~en_set & ~st_r.pin_q & st_r.enabled
                       & (st_r.tmr >= OFF_CYC);

    always_comb begin
        st_nxt = st_r;
        st_nxt.pin_q = en_set;
        if (en_set != st_r.pin_q) begin
            st_nxt.tmr = '0;
        end else if (st_r.tmr != '1) begin
            st_nxt.tmr = st_r.tmr + 1'b1;
        end
        if (rise) begin
            st_nxt.enabled = 1'b1;
            st_nxt.pending = 1'b1;
            if (st_r.edges != 5'd16) begin
                st_nxt.edges = st_r.edges + 5'd1;
            end
        end
        if (latch_now) begin
            st_nxt.code    = 4'(st_r.edges - 5'd1);
            st_nxt.pending = 1'b0;
            st_nxt.edges   = '0;
        end
        if (off_now) begin
            st_nxt.enabled = 1'b0;
            st_nxt.pending = 1'b0;
            st_nxt.edges   = '0;
            st_nxt.code    = pcv_pkg::CODE_DEFAULT;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reference selection
    always_comb begin
        ref_nxt = '0;
        ref_nxt.low_ref_code = st_r.code;
        if (ref_sel) begin
            ref_nxt.high_ref_en = 1'b1;
            ref_nxt.ref_mv      = pcv_pkg::HIGH_REF_MV;
        end else begin
            ref_nxt.low_ref_en = 1'b1;
            ref_nxt.ref_mv = pcv_pkg::LOW_REF_BASE_MV
                + 11'(pcv_pkg::LOW_REF_STEP_MV * st_r.code);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ref_out <= '0;
        end else begin
            ref_out <= ref_nxt;
        end
    end

    assign enabled = st_r.enabled;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_edge_counts: assert property (
        @(posedge mclk) disable iff (!rst_n)
        rise && st_r.edges < 5'h10
        |=> st_r.edges == $past(st_r.edges) + 5'h01)
        else $error("rising edge not counted");

    a_edge_saturate: assert property (
        @(posedge mclk) disable iff (!rst_n)
        st_r.edges <= 5'h10)
        else $error("edge count beyond sixteen");

    a_sat_hold: assert property (
        @(posedge mclk) disable iff (!rst_n)
        rise && st_r.edges == 5'h10
        |=> st_r.edges == 5'h10)
        else $error("edge count wrapped");

    a_edge_holds: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !rise && !latch_now && !off_now
        |=> st_r.edges == $past(st_r.edges))
        else $error("edge count moved without an edge");

    a_pin_track: assert property (
        @(posedge mclk) disable iff (!rst_n)
        1'b1
        |=> st_r.pin_q == $past(en_set))
        else $error("pin sample lost");

    a_tmr_restart: assert property (
        @(posedge mclk) disable iff (!rst_n)
        en_set != st_r.pin_q
        |=> st_r.tmr == '0)
        else $error("phase timer not restarted");

    a_tmr_count: assert property (
        @(posedge mclk) disable iff (!rst_n)
        en_set == st_r.pin_q && st_r.tmr != '1
        |=> st_r.tmr == $past(st_r.tmr) + 1'b1)
        else $error("phase timer not counting");

    a_tmr_hold: assert property (
        @(posedge mclk) disable iff (!rst_n)
        en_set == st_r.pin_q && st_r.tmr == '1
        |=> st_r.tmr == '1)
        else $error("phase timer wrapped");

    a_rise_enables: assert property (
        @(posedge mclk) disable iff (!rst_n)
        rise
        |=> st_r.enabled && st_r.pending)
        else $error("rising edge did not enable");

    a_on_rise: assert property (
        @(posedge mclk) disable iff (!rst_n)
        rise && !st_r.enabled
        |=> st_r.edges == 5'h01)
        else $error("enabling edge not counted as first");

    a_pend_edges: assert property (
        @(posedge mclk) disable iff (!rst_n)
        st_r.pending == (st_r.edges != 5'h00))
        else $error("pending flag and edge count disagree");

    a_pend_on: assert property (
        @(posedge mclk) disable iff (!rst_n)
        st_r.pending |-> st_r.enabled)
        else $error("pending while disabled");

    a_latch_code: assert property (
        @(posedge mclk) disable iff (!rst_n)
        latch_now
        |=> st_r.code == 4'($past(st_r.edges) - 5'h01))
        else $error("latched code mismatch");

    a_latch_clears: assert property (
        @(posedge mclk) disable iff (!rst_n)
        latch_now
        |=> !st_r.pending && st_r.edges == 5'h00)
        else $error("latch did not restart the count");

    a_latch_wait: assert property (
        @(posedge mclk) disable iff (!rst_n)
        en_set && st_r.pin_q && st_r.pending && st_r.tmr < LAT_CYC
        |=> st_r.pending)
        else $error("latched before the hold time");

    a_latch_high: assert property (
        @(posedge mclk) disable iff (!rst_n)
        $fell(st_r.pending) && $past(rst_n)
        |-> $past(en_set) || !st_r.enabled)
        else $error("latched while pin low");

    a_code_stable: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !latch_now && !off_now
        |=> st_r.code == $past(st_r.code))
        else $error("stored code changed without latch");

    a_off_time: assert property (
        @(posedge mclk) disable iff (!rst_n)
        $fell(st_r.enabled) && $past(rst_n)
        |-> !$past(en_set) && $past(st_r.tmr) >= OFF_CYC)
        else $error("disabled before the shutdown time");

    a_off_default: assert property (
        @(posedge mclk) disable iff (!rst_n)
        $fell(st_r.enabled)
        |-> st_r.code == pcv_pkg::CODE_DEFAULT)
        else $error("setting not cleared on disable");

    a_off_clears: assert property (
        @(posedge mclk) disable iff (!rst_n)
        off_now
        |=> !st_r.enabled && !st_r.pending && st_r.edges == 5'h00)
        else $error("shutdown left state behind");

    a_off_wait: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !en_set && !st_r.pin_q && st_r.enabled && st_r.tmr < OFF_CYC
        |=> st_r.enabled)
        else $error("disabled on a short low phase");

    a_stay_off: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !st_r.enabled && !rise
        |=> !st_r.enabled)
        else $error("enabled without a rising edge");

    a_high_ref: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ref_sel |=> ref_out.high_ref_en && !ref_out.low_ref_en
            && ref_out.ref_mv == pcv_pkg::HIGH_REF_MV)
        else $error("high reference not selected");

    a_low_ref: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !ref_sel |=> ref_out.low_ref_en && !ref_out.high_ref_en
            && ref_out.ref_mv == pcv_pkg::LOW_REF_BASE_MV
            + 11'(pcv_pkg::LOW_REF_STEP_MV * $past(st_r.code)))
        else $error("low reference level wrong");

    a_one_ref: assert property (
        @(posedge mclk) disable iff (!rst_n)
        1'b1
        |=> ref_out.high_ref_en != ref_out.low_ref_en)
        else $error("not exactly one reference enabled");

    a_ref_range: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ref_out.low_ref_en
        |-> ref_out.ref_mv >= pcv_pkg::LOW_REF_BASE_MV
            && ref_out.ref_mv <= pcv_pkg::HIGH_REF_MV)
        else $error("low reference out of range");

    a_code_out: assert property (
        @(posedge mclk) disable iff (!rst_n)
        1'b1
        |=> ref_out.low_ref_code == $past(st_r.code))
        else $error("code output does not follow store");

    a_reset_default: assert property (
        @(posedge mclk)
        !rst_n
        |=> st_r.code == pcv_pkg::CODE_DEFAULT && !st_r.pending)
        else $error("reset default wrong");

    c_latch:  cover property (@(posedge mclk) disable iff (!rst_n)
        $fell(st_r.pending) && st_r.code == 4'h3);
    c_sat:    cover property (@(posedge mclk) disable iff (!rst_n)
        st_r.edges == 5'd16 && rise);
    c_off:    cover property (@(posedge mclk) disable iff (!rst_n)
        $fell(st_r.enabled));
    c_hisel:  cover property (@(posedge mclk) disable iff (!rst_n)
        $rose(ref_sel));
endmodule : pcv_select

/* File: bench/pcv_host.sv */
`timescale 1ns/1ps
module pcv_host #(
    parameter int LAT = 40,
    parameter int OFF = 100
) (
    input  wire logic mclk,
    output logic      en_set,
    output logic      ref_sel
);
    initial en_set = 1'b0;
    initial ref_sel = 1'b0;
    // tasks are entered and left one time unit after a rising edge
    task automatic hold(input logic v, input int n);
        en_set = v;
        repeat (n) @(posedge mclk);
        #1;
    endtask : hold
    task automatic send(input int n);
        for (int i = 0; i < n; i++) begin
            hold(1'b0, pcv_pkg::MIN_PHASE_CYC);
            hold(1'b1, pcv_pkg::MIN_PHASE_CYC + 1);
        end
        hold(1'b1, LAT + 6);
    endtask : send
    task automatic sel(input logic v);
        ref_sel = v;
        repeat (3) @(posedge mclk);
        #1;
    endtask : sel
endmodule : pcv_host

/* File: bench/tb.sv */
`timescale 1ns/1ps
module tb;
    localparam logic [15:0] LAT = 16'h0028;
    localparam logic [15:0] OFF = 16'h0064;
    logic              mclk = 1'b0;
    logic              rst_n = 1'b0;
    logic              en_set;
    logic              ref_sel;
    logic              enabled;
    pcv_pkg::pcv_ref_t ref_out;
    int                mismatches = 0;
    int                check_count = 0;
    always #20 mclk = ~mclk;
    pcv_host #(.LAT(LAT), .OFF(OFF)) host (.mclk(mclk), .en_set(en_set),
        .ref_sel(ref_sel));
    pcv_select #(.LAT_CYC(LAT), .OFF_CYC(OFF)) dut (.mclk(mclk),
        .rst_n(rst_n), .en_set(en_set), .ref_sel(ref_sel),
        .enabled(enabled), .ref_out(ref_out));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [10:0] exp,
                       input logic [10:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s exp %h got %h", what, exp, got);
        end
    endtask : chk
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////////
    task automatic t_levels();
        logic [3:0] c;
        chk("mv_pwr", 11'h258, ref_out.ref_mv);
        for (int n = 1; n <= 17; n++) begin
            host.send(n);
            c = (n > 16) ? 4'hF : 4'(n - 1);
            chk("code", {7'h00, c}, {7'h00, ref_out.low_ref_code});
            chk("mv", 11'h258 + 11'h028 * c, ref_out.ref_mv);
            chk("low_en", 11'h001, {10'h000, ref_out.low_ref_en});
        end
    endtask : t_levels
    task automatic t_sel();
        host.send(3);
        host.sel(1'b1);
        chk("mv_hi", 11'h4B0, ref_out.ref_mv);
        chk("hi_en", 11'h001, {10'h000, ref_out.high_ref_en});
        chk("lo_en", 11'h000, {10'h000, ref_out.low_ref_en});
        host.sel(1'b0);
        chk("mv_lo", 11'h2A8, ref_out.ref_mv);
    endtask : t_sel
    task automatic t_off();
        host.hold(1'b0, OFF - 20);
        chk("en_short", 11'h001, {10'h000, enabled});
        host.hold(1'b0, 26);
        chk("en_off", 11'h000, {10'h000, enabled});
        host.hold(1'b1, 5);
        chk("en_on", 11'h001, {10'h000, enabled});
        chk("mv_def", 11'h258, ref_out.ref_mv);
        host.hold(1'b1, LAT + 1);
        chk("mv_lat", 11'h258, ref_out.ref_mv);
    endtask : t_off
    ////////////////////////////////////////////////////////////////////
    initial begin
        #(40 * 20000);
        mismatches++;
        print_verdict();
    end
    initial begin
        repeat (2) @(posedge mclk);
        #1 rst_n = 1'b1;
        @(posedge mclk);
        #1;
        t_levels();
        t_sel();
        t_off();
        print_verdict();
    end
endmodule : tb
